// ---- hdl/timer_cc_consts.vh ----
/*
 * Constants of the two-channel timer capture/compare block.
 * Assumes it is included by bare name in every file that needs it.
 */
`ifndef TIMER_CC_CONSTS_VH
`define TIMER_CC_CONSTS_VH

// ********************
// Register word indices
// ********************
// Byte address is four times the index.
`define IDX_W 6
`define IDX_CTRL0 6'h25
`define IDX_VAL0_HI 6'h26
`define IDX_VAL0_LO 6'h27
`define IDX_CTRL1 6'h28
`define IDX_VAL1_HI 6'h29
`define IDX_VAL1_LO 6'h2A
`define IDX_STATUS 6'h30
`define IDX_MASK 6'h31

// ********************
// Channel control fields
// ********************
`define CTL_W 6
`define CTL_MAX 0
`define CTL_TOV 1
`define CTL_ELS_LO 2
`define CTL_ELS_HI 3
`define CTL_CCSEL 4
`define CTL_BUF 5
`define CTL_RESET 6'h00
// Only channel 0 owns the buffered mode bit.
`define CTL_MASK0 6'h3F
`define CTL_MASK1 6'h1F

// ********************
// Edge/level codes
// ********************
`define ELS_OFF 2'b00
`define ELS_RISE 2'b01
`define ELS_FALL 2'b10
`define ELS_ANY 2'b11

// ********************
// Reset values
// ********************
`define VAL_RESET 16'h0000
`define DAT_ZERO 32'h0000_0000
`define CH_RESET 2'b00

`endif

// ---- hdl/pin_sync.v ----
/*
 * Two-flop synchroniser for one channel pin with edge pulses.
 * Assumes the pin is asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "timer_cc_consts.vh"

// ********************
// Pin synchroniser
// ********************
module pin_sync (
    input wire sys_clk,
    input wire reset,
    input wire pin,
    output wire rise,
    output wire fall
);
    reg meta; // First stage, read only by the second stage.
    reg level; // Synchronised pin level.
    reg prev; // Level one cycle earlier, for edge detection.

    // A pin held high through reset shows one rising edge after release.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule // pin_sync

// ---- hdl/channel_output.v ----
/*
 * Output stage of one channel: compare actions, overflow toggle,
 * full-duty forcing and preset level.
 * Assumes overflow and compare_hit are one-cycle sys_clk pulses.
 */
`timescale 1ns/1ps
`include "timer_cc_consts.vh"

// ********************
// Channel output stage
// ********************
module channel_output (
    input wire sys_clk,
    input wire reset,
    input wire [1:0] els,
    input wire out_mode,
    input wire preset_low,
    input wire tov,
    input wire max_duty,
    input wire enable,
    input wire overflow,
    input wire compare_hit,
    output reg pin_out,
    output reg pin_oe
);
    reg max_active; // Full duty as seen by the current period.
    wire full_level; // Level meaning 100% duty for this polarity.

    // Clear-on-compare gives polarity 1; set-on-compare polarity 0.
    assign full_level = (els != `ELS_ANY);

    // The pin is driven only as an enabled output with a nonzero code.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pin_out <= 1'b1;
            pin_oe <= 1'b0;
            max_active <= 1'b0;
        end else begin
            pin_oe <= enable & out_mode & (els != `ELS_OFF);
            // Full duty only changes at a period boundary.
            if (overflow) begin
                max_active <= max_duty & tov;
            end
            if (els == `ELS_OFF) begin
                // Preset level; the pin itself belongs to the port.
                pin_out <= ~preset_low;
            end else if (!out_mode) begin
                pin_out <= pin_out; // Capture channels hold the level.
            end else if (max_active) begin
                pin_out <= full_level;
            end else if (overflow && tov) begin
                // Overflow wins over a compare in the same cycle.
                pin_out <= ~pin_out;
            end else if (compare_hit) begin
                case (els)
                    `ELS_RISE: pin_out <= ~pin_out;
                    `ELS_FALL: pin_out <= 1'b0;
                    default: pin_out <= 1'b1;
                endcase
            end
        end
    end
endmodule // channel_output

// ---- hdl/timer_cc.v ----
/*
 * Two-channel capture/compare section of a 16-bit timer, with a
 * classic Wishbone register slave and a level interrupt.
 * Assumes the shared counter, its tick and overflow pulses and the
 * stop level come from logic on sys_clk; pins are asynchronous.
 */
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "timer_cc_consts.vh"
// Function
// - Edge select picks the active capture edge.
// - Edge select picks the compare output action.
// - Code 00 leaves the pin to the port.
// - Reset clears both edge select bits.
// - Toggle on overflow inverts the output pin.
// - Toggle bit ignored on capture; reset clears.
// - Overflow beats compare in the same cycle.
// - Full-duty bit forces 100% with toggle set.
// - Full-duty change waits for next period.
// - Full duty level follows the PWM polarity.
// - Each channel holds a 16-bit value.
// - High byte read blocks capture until low.
// - High byte write blocks compare until low.
// - Codes select rising, falling, any edge action.
// - Flag set on capture edge or match.

// ********************
// Top module
// ********************
module timer_cc (
    input wire sys_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [15:0] counter_value,
    input wire counter_tick,
    input wire counter_overflow,
    input wire counter_stopped,
    input wire [1:0] channel_pin_in,
    output wire [1:0] channel_pin_out,
    output wire [1:0] channel_pin_oe,
    output reg irq
);
    // Number of channels; the register map is laid out for two.
    localparam CHANNELS = 2;

    // ********************
    // Bus decode
    // ********************

    wire [`IDX_W-1:0] idx; // Word index of the current access.
    wire req; // A new request, taken in the cycle before ack.
    wire wr; // Write that reaches the low byte lane.
    wire rd; // Read request.

    assign idx = wb_adr_i[7:2];
    // Each access is acknowledged once, one cycle after it is taken.
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign rd = req & ~wb_we_i;

    // ********************
    // Shared state
    // ********************

    reg [1:0] mask; // Interrupt mask, one bit per channel.
    reg buf_src; // Channel whose value was completed last.
    reg [15:0] shadow; // Compare value used in buffered mode.
    reg [31:0] next_dat; // Read data for the current request.

    wire [CHANNELS*`CTL_W-1:0] ctrl_bus; // Control of all channels.
    wire [CHANNELS*16-1:0] value_bus; // Values of all channels.
    wire [CHANNELS-1:0] flag_bus; // Event flags of all channels.
    wire buffered; // Channel 0 runs buffered and owns channel 1.

    assign buffered = ctrl_bus[`CTL_BUF];

    // ********************
    // Per-channel logic
    // ********************

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : ch
            // Register indices of this channel.
            localparam [`IDX_W-1:0] CTL_IDX = (i == 0) ? `IDX_CTRL0 : `IDX_CTRL1;
            localparam [`IDX_W-1:0] HI_IDX = (i == 0) ? `IDX_VAL0_HI : `IDX_VAL1_HI;
            localparam [`IDX_W-1:0] LO_IDX = (i == 0) ? `IDX_VAL0_LO : `IDX_VAL1_LO;
            localparam [`CTL_W-1:0] CTL_MASK = (i == 0) ? `CTL_MASK0 : `CTL_MASK1;

            reg [`CTL_W-1:0] ctrl; // Mode, edge/level, toggle, full duty.
            reg [15:0] value; // Captured or compare value.
            reg read_lock; // Captures blocked after a high byte read.
            reg write_lock; // Compares blocked after a high byte write.
            reg flag; // Sticky channel event flag.

            wire [1:0] els; // Edge/level select code.
            wire disabled; // Channel 1 is given back to the port.
            wire out_mode; // Output compare or PWM.
            wire capture_mode; // Active input capture.
            wire rise; // Synchronised rising edge.
            wire fall; // Synchronised falling edge.
            wire active_edge; // Edge chosen by the select code.
            wire capture; // Capture event this cycle.
            wire [15:0] cmp_val; // Value the counter is compared with.
            wire compare_hit; // Compare event this cycle.
            wire flag_clear; // Write of one to this status bit.

            assign els = ctrl[`CTL_ELS_HI:`CTL_ELS_LO];
            assign disabled = (i != 0) && buffered;
            assign out_mode = ctrl[`CTL_CCSEL] | ((i == 0) && buffered);
            assign capture_mode = ~out_mode & (els != `ELS_OFF) & ~disabled;

            // The pin is synchronised before any logic reads it.
            pin_sync sync (
                .sys_clk(sys_clk),
                .reset(reset),
                .pin(channel_pin_in[i]),
                .rise(rise),
                .fall(fall)
            );

            // Code 01 rising, 10 falling, 11 both edges.
            assign active_edge = (els[0] & rise) | (els[1] & fall);
            // A stopped counter inhibits capture as well.
            assign capture = capture_mode & active_edge & ~read_lock & ~counter_stopped;
            assign cmp_val = ((i == 0) && buffered) ? shadow : value;
            // Matching only on a counter tick keeps one event per count.
            assign compare_hit = out_mode & ~disabled & ~write_lock & counter_tick
                & (counter_value == cmp_val);
            assign flag_clear = wr & (idx == `IDX_STATUS) & wb_dat_i[i];

            // Control register; reset clears edge, toggle and duty bits.
            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    ctrl <= `CTL_RESET;
                end else if (wr && idx == CTL_IDX) begin
                    ctrl <= wb_dat_i[`CTL_W-1:0] & CTL_MASK;
                end
            end

            // Value register: a bus write overrides a capture in the same cycle.
            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    value <= `VAL_RESET;
                end else if (wr && idx == HI_IDX) begin
                    value[15:8] <= wb_dat_i[7:0];
                end else if (wr && idx == LO_IDX) begin
                    value[7:0] <= wb_dat_i[7:0];
                end else if (capture) begin
                    value <= counter_value;
                end
            end

            // Byte coherency locks for capture reads and compare writes.
            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    read_lock <= 1'b0;
                    write_lock <= 1'b0;
                end else begin
                    if (rd && idx == LO_IDX) begin
                        read_lock <= 1'b0;
                    end else if (rd && idx == HI_IDX && !out_mode) begin
                        read_lock <= 1'b1;
                    end
                    if (wr && idx == LO_IDX) begin
                        write_lock <= 1'b0;
                    end else if (wr && idx == HI_IDX && out_mode) begin
                        write_lock <= 1'b1;
                    end
                end
            end

            // Event flag: a new event wins over a clear in the same cycle.
            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    flag <= 1'b0;
                end else if (capture || compare_hit) begin
                    flag <= 1'b1;
                end else if (flag_clear) begin
                    flag <= 1'b0;
                end
            end

            // Pin drive: compare actions, overflow toggle and full duty.
            channel_output out (
                .sys_clk(sys_clk),
                .reset(reset),
                .els(els),
                .out_mode(out_mode),
                .preset_low(ctrl[`CTL_CCSEL]),
                .tov(ctrl[`CTL_TOV]),
                .max_duty(ctrl[`CTL_MAX]),
                .enable(~disabled),
                .overflow(counter_overflow),
                .compare_hit(compare_hit),
                .pin_out(channel_pin_out[i]),
                .pin_oe(channel_pin_oe[i])
            );

            assign ctrl_bus[i*`CTL_W +: `CTL_W] = ctrl;
            assign value_bus[i*16 +: 16] = value;
            assign flag_bus[i] = flag;
        end
    endgenerate

    // ********************
    // Buffered compare
    // ********************

    // The shadow is reloaded only at overflow, so a new duty never
    // lands in the middle of a period; the last completed value wins.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            buf_src <= 1'b0;
            shadow <= `VAL_RESET;
        end else begin
            if (wr && idx == `IDX_VAL0_LO) begin
                buf_src <= 1'b0;
            end else if (wr && idx == `IDX_VAL1_LO) begin
                buf_src <= 1'b1;
            end
            if (counter_overflow) begin
                shadow <= buf_src ? value_bus[31:16] : value_bus[15:0];
            end
        end
    end

    // ********************
    // Interrupt
    // ********************

    // Mask register; the interrupt is registered, so it lags the flag by a cycle.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mask <= `CH_RESET;
            irq <= 1'b0;
        end else begin
            if (wr && idx == `IDX_MASK) begin
                mask <= wb_dat_i[1:0];
            end
            irq <= |(flag_bus & mask);
        end
    end

    // ********************
    // Read mux
    // ********************

    // Narrow registers sit in the low bits; unmapped words read zero.
    always @* begin
        next_dat = `DAT_ZERO;
        case (idx)
            `IDX_CTRL0: next_dat[`CTL_W-1:0] = ctrl_bus[5:0];
            `IDX_CTRL1: next_dat[`CTL_W-1:0] = ctrl_bus[11:6];
            `IDX_VAL0_HI: next_dat[7:0] = value_bus[15:8];
            `IDX_VAL0_LO: next_dat[7:0] = value_bus[7:0];
            `IDX_VAL1_HI: next_dat[7:0] = value_bus[31:24];
            `IDX_VAL1_LO: next_dat[7:0] = value_bus[23:16];
            `IDX_STATUS: next_dat[1:0] = flag_bus;
            `IDX_MASK: next_dat[1:0] = mask;
            default: next_dat = `DAT_ZERO;
        endcase
    end

    // ********************
    // Bus answer
    // ********************

    // Every request, mapped or not, is answered after one wait-free cycle.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `DAT_ZERO;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= next_dat;
            end
        end
    end
endmodule // timer_cc

// ---- verif/timer_cc_properties.sv ----
/* Port checks of timer_cc: bus answer, interrupt, channel 0 pin.
   Assumes one clock and a bind to timer_cc at the foot of this file. */
`timescale 1ns/1ps
`include "timer_cc_consts.vh"
// ********
// Checker
// ********
module timer_cc_properties (
    input wire sys_clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire counter_tick,
    input wire counter_overflow,
    input wire [1:0] channel_pin_out,
    input wire [1:0] channel_pin_oe,
    input wire irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    reg [5:0] ctl; // Shadow of channel 0 control.
    reg [1:0] msk; // Shadow of the mask.
    reg lat; // Full duty as latched at the last overflow.
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i && wb_sel_i[0];
    wire [1:0] els = ctl[3:2];
    wire omode = ctl[`CTL_CCSEL] && !ctl[`CTL_BUF] && els != 2'h0;
    // Follow the bus writes; the shadows only see taken requests.
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctl <= 6'h00;
            msk <= 2'h0;
            lat <= 1'b0;
        end else begin
            if (wr && wb_adr_i[7:2] == `IDX_CTRL0) ctl <= wb_dat_i[5:0];
            if (wr && wb_adr_i[7:2] == `IDX_MASK) msk <= wb_dat_i[1:0];
            if (counter_overflow) lat <= ctl[`CTL_MAX] && ctl[`CTL_TOV];
        end
    end
    property p_ack_next;
        req |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_rd_width;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read data above the byte");
    property p_irq_mask;
        (msk == 2'h0) [*2] |-> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while all masked");
    property p_off_oe;
        (els == 2'h0 && $stable(ctl)) [*3] |-> !channel_pin_oe[0];
    endproperty
    a_off_oe: assert property (p_off_oe) else $error("pin driven with code 00");
    property p_off_lvl;
        (els == 2'h0 && $stable(ctl)) [*3] |-> channel_pin_out[0] == !ctl[`CTL_CCSEL];
    endproperty
    a_off_lvl: assert property (p_off_lvl) else $error("preset level wrong");
    property p_cap_oe;
        (!ctl[`CTL_CCSEL] && !ctl[`CTL_BUF]) [*3] |-> !channel_pin_oe[0];
    endproperty
    a_cap_oe: assert property (p_cap_oe) else $error("capture pin driven");
    property p_tov;
        counter_overflow && omode && ctl[`CTL_TOV] && !lat && !ctl[`CTL_MAX] && !wb_cyc_i
            |=> channel_pin_out[0] != $past(channel_pin_out[0]);
    endproperty
    a_tov: assert property (p_tov) else $error("no toggle at overflow");
    property p_no_tov;
        counter_overflow && omode && !ctl[`CTL_TOV] && !lat && !counter_tick && !wb_cyc_i
            |=> $stable(channel_pin_out[0]);
    endproperty
    a_no_tov: assert property (p_no_tov) else $error("pin moved at overflow");
    property p_full;
        (lat && ctl[`CTL_TOV] && omode) [*2] |-> channel_pin_out[0] == (els != 2'h3);
    endproperty
    a_full: assert property (p_full) else $error("full duty level wrong");
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_irq: cover property (irq);
    c_full: cover property (lat && omode);
endmodule // timer_cc_properties

bind timer_cc timer_cc_properties i_timer_cc_properties (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .counter_tick,
    .counter_overflow, .channel_pin_out, .channel_pin_oe, .irq);

// ---- verif/pin_model.sv ----
/* Far side of the two channel pins: a source that the bench steers.
   Assumes the block's enable wins over the source, as on a real pad. */
`timescale 1ns/1ps
// ********
// Pin model
// ********
module pin_model (
    input wire [1:0] drive,
    input wire [1:0] pin_out,
    input wire [1:0] pin_oe,
    output wire [1:0] pin
);
    // The wire level: the block while it drives, the source otherwise.
    assign pin = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule // pin_model

// ---- verif/tb.sv ----
/* Self-checking bench of timer_cc over Wishbone and the pins.
   Assumes timer_cc, pin_model and the checker are compiled alongside. */
`timescale 1ns/1ps
`include "timer_cc_consts.vh"
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
// ********
// Bench
// ********
module tb;
    reg sys_clk = 1'b0;
    reg reset = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'h1;
    reg [31:0] wdat = 32'h0000_0000;
    reg [15:0] cv = 16'h0000;
    reg tick = 1'b0;
    reg ovf = 1'b0;
    reg stopped = 1'b0;
    reg [1:0] drive = 2'h0;
    wire [31:0] rdat;
    wire ack;
    wire [1:0] pout;
    wire [1:0] poe;
    wire [1:0] pin;
    wire irq;
    int err_count = 0;
    int n_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    timer_cc i_timer_cc (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .counter_value(cv), .counter_tick(tick), .counter_overflow(ovf),
        .counter_stopped(stopped), .channel_pin_in(pin), .channel_pin_out(pout),
        .channel_pin_oe(poe), .irq(irq));
    pin_model i_pin_model (.drive(drive), .pin_out(pout), .pin_oe(poe), .pin(pin));
    // One classic cycle; the request stands until ack is sampled high.
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'h0};
        wdat <= {24'h00_0000, d};
        @(posedge sys_clk);
        // No local limit: only the watchdog ends a wait for ack.
        while (ack !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, i, d, q);
    endtask
    task automatic rc(input logic [5:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, i, 8'h00, q);
        `CHK(q, e, "register read")
    endtask
    // One-cycle counter events, then time for pin and flag to land.
    task automatic pulse(input logic t, input logic o, input logic [15:0] v);
        @(posedge sys_clk);
        tick <= t;
        ovf <= o;
        cv <= v;
        @(posedge sys_clk);
        tick <= 1'b0;
        ovf <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    // Slow edge on pin 0; the synchroniser needs several cycles.
    task automatic pin0(input logic l, input logic [15:0] v);
        @(posedge sys_clk);
        drive[0] <= l;
        cv <= v;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic t_regs;
        rc(`IDX_CTRL0, 8'h00);
        rc(`IDX_CTRL1, 8'h00);
        rc(6'h00, 8'h00);
        wr(`IDX_CTRL1, 8'hFF);
        rc(`IDX_CTRL1, 8'h1F);
        wr(`IDX_CTRL1, 8'h00);
        `CHK(poe, 2'h0, "pins released")
        wr(`IDX_CTRL0, 8'h10);
        `CHK(pout[0], 1'b0, "preset low")
        wr(`IDX_CTRL0, 8'h00);
    endtask
    task automatic t_compare;
        logic [1:0] code [3] = '{2'h2, 2'h3, 2'h1};
        logic p;
        wr(`IDX_VAL1_HI, 8'h12);
        wr(`IDX_VAL1_LO, 8'h34);
        for (int k = 0; k < 3; k++) begin
            wr(`IDX_CTRL1, {4'h1, code[k], 2'h0});
            wr(`IDX_STATUS, 8'h03);
            p = pout[1];
            pulse(1'b1, 1'b0, 16'h1234);
            `CHK(poe[1], 1'b1, "compare drive")
            `CHK(pout[1], (code[k] == 2'h1) ? !p : code[k][0], "compare action")
            rc(`IDX_STATUS, 8'h02);
        end
        wr(`IDX_STATUS, 8'h03);
        wr(`IDX_VAL1_HI, 8'h56);
        pulse(1'b1, 1'b0, 16'h5634);
        rc(`IDX_STATUS, 8'h00);
        wr(`IDX_VAL1_LO, 8'h34);
        pulse(1'b1, 1'b0, 16'h5634);
        rc(`IDX_STATUS, 8'h02);
        wr(`IDX_MASK, 8'h02);
        `CHK(irq, 1'b1, "irq raised")
        wr(`IDX_MASK, 8'h00);
        `CHK(irq, 1'b0, "irq masked")
        wr(`IDX_MASK, 8'h02);
        wr(`IDX_STATUS, 8'h02);
        `CHK(irq, 1'b0, "irq cleared")
    endtask
    task automatic t_capture;
        logic [15:0] v;
        for (int c = 1; c < 4; c++) begin
            wr(`IDX_CTRL0, {4'h0, c[1:0], 2'h0});
            wr(`IDX_STATUS, 8'h01);
            pin0(1'b1, 16'hA500 + c[15:0]);
            rc(`IDX_STATUS, {7'h00, c[0]});
            wr(`IDX_STATUS, 8'h01);
            pin0(1'b0, 16'h3C00 + c[15:0]);
            rc(`IDX_STATUS, {7'h00, c[1]});
            v = c[1] ? 16'h3C00 + c[15:0] : 16'hA500 + c[15:0];
            rc(`IDX_VAL0_HI, v[15:8]);
            rc(`IDX_VAL0_LO, v[7:0]);
        end
        wr(`IDX_CTRL0, 8'h04);
        rc(`IDX_VAL0_HI, v[15:8]);
        pin0(1'b1, 16'h7777);
        rc(`IDX_VAL0_LO, v[7:0]);
        pin0(1'b0, 16'h0000);
        pin0(1'b1, 16'h8888);
        rc(`IDX_VAL0_HI, 8'h88);
        rc(`IDX_VAL0_LO, 8'h88);
        // A stopped counter must not capture an active edge.
        @(posedge sys_clk);
        stopped <= 1'b1;
        pin0(1'b0, 16'h0000);
        pin0(1'b1, 16'h9999);
        rc(`IDX_VAL0_LO, 8'h88);
        @(posedge sys_clk);
        stopped <= 1'b0;
    endtask
    task automatic t_tov;
        wr(`IDX_CTRL0, 8'h1A);
        wr(`IDX_VAL0_HI, 8'h00);
        wr(`IDX_VAL0_LO, 8'h40);
        pulse(1'b1, 1'b0, 16'h0040);
        `CHK(pout[0], 1'b0, "clear on compare")
        pulse(1'b1, 1'b1, 16'h0040);
        `CHK(pout[0], 1'b1, "overflow wins")
        pulse(1'b0, 1'b1, 16'h0000);
        `CHK(pout[0], 1'b0, "overflow toggle")
        wr(`IDX_CTRL0, 8'h18);
        pulse(1'b0, 1'b1, 16'h0000);
        `CHK(pout[0], 1'b0, "no toggle")
        wr(`IDX_CTRL0, 8'h06);
        pulse(1'b0, 1'b1, 16'h0000);
        `CHK(poe[0], 1'b0, "capture ignores toggle")
        `CHK(pout[0], 1'b0, "capture holds level")
    endtask
    task automatic t_full;
        wr(`IDX_CTRL0, 8'h1A);
        // The released pin gave channel 0 a capture; restore the compare value.
        wr(`IDX_VAL0_HI, 8'h00);
        wr(`IDX_VAL0_LO, 8'h40);
        pulse(1'b1, 1'b0, 16'h0040);
        wr(`IDX_CTRL0, 8'h1B);
        `CHK(pout[0], 1'b0, "full duty waits")
        pulse(1'b0, 1'b1, 16'h0000);
        `CHK(pout[0], 1'b1, "full duty high")
        pulse(1'b1, 1'b0, 16'h0040);
        pulse(1'b0, 1'b1, 16'h0000);
        `CHK(pout[0], 1'b1, "full duty holds")
        wr(`IDX_CTRL0, 8'h1A);
        pulse(1'b1, 1'b0, 16'h0040);
        `CHK(pout[0], 1'b1, "full duty to period end")
        pulse(1'b0, 1'b1, 16'h0000);
        pulse(1'b1, 1'b0, 16'h0040);
        `CHK(pout[0], 1'b0, "full duty released")
        wr(`IDX_CTRL0, 8'h1F);
        pulse(1'b0, 1'b1, 16'h0000);
        pulse(1'b1, 1'b0, 16'h0040);
        `CHK(pout[0], 1'b0, "full duty other level")
        // Buffered mode: channel 1 is released and channel 0 uses the shadow.
        wr(`IDX_CTRL0, 8'h2C);
        wr(`IDX_VAL1_HI, 8'h00);
        wr(`IDX_VAL1_LO, 8'h50);
        `CHK(poe[1], 1'b0, "buffered releases pin 1")
        pulse(1'b0, 1'b1, 16'h0000);
        pulse(1'b1, 1'b0, 16'h0050);
        `CHK(pout[0], 1'b1, "buffered set on compare")
    endtask
    // A second reset in mid-run must clear the control bits again.
    task automatic t_rst;
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        rc(`IDX_CTRL0, 8'h00);
    endtask
    task test_done;
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs;
        t_compare;
        t_capture;
        t_tov;
        t_full;
        t_rst;
        test_done;
    end
    // Watchdog: the whole run needs well under this many cycles.
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        test_done;
    end
endmodule // tb
